// ---- core/pdl_pkg.sv ----
// Constants shared by the parallel DAC input latch design
package pdl_pkg;
  // Word width of the widest family member
  localparam int unsigned DATA_W = 16;
  // Bits that feed the segmented (thermometer) part
  localparam int unsigned SEG_BITS = 4;
  // Number of equal current segments
  localparam int unsigned SEG_N = 15;
  // Bits that stay binary weighted
  localparam int unsigned BIN_W = DATA_W - SEG_BITS;
  // Differential output width, one bit wider than the word plus sign
  localparam int unsigned DIFF_W = DATA_W + 2;
  // Largest code, all ones
  localparam logic [DATA_W-1:0] CODE_MAX = 16'hFFFF;
  // Mid-scale code
  localparam logic [DATA_W-1:0] CODE_MID = 16'h8000;
  // Reset value of captured word and primary output
  localparam logic [DATA_W-1:0] RST_CODE = 16'h0000;
  // Differential value after reset: code zero minus full scale, i.e. -65535
  localparam logic signed [DIFF_W-1:0] RST_DIFF = 18'sh30001;
  // FIFO depth in front of the latch
  localparam int unsigned FIFO_DEPTH = 32;
  // Pointer width for the FIFO depth
  localparam int unsigned FIFO_AW = 5;
  // Latch sequencer states, one-hot
  typedef enum logic [1:0] {
    PDL_IDLE = 2'b01,
    PDL_RUN = 2'b10
  } pdl_state_e;
endpackage

// ---- core/pdl_fifo.sv ----
// Sample FIFO with valid/ready on both sides, flip-flop storage
`timescale 1ns/1ps
module pdl_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = 5
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  // Whole state in one struct
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] count;
    logic ready; // Registered not-full, so in_ready comes from a flop
  } pdl_fifo_s;

  pdl_fifo_s st;
  pdl_fifo_s next_st;
  logic push;
  logic pop;

  // Handshakes; full stalls the source, empty stalls the drain
  assign push = in_valid && st.ready;
  assign pop = out_ready && (st.count != '0);
  assign in_ready = st.ready;
  assign out_valid = (st.count != '0);
  assign out_data = st.mem[st.rd];

  // Next state: write, read and occupancy
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = st.wr + AW'(1);
    end
    if (pop) begin
      next_st.rd = st.rd + AW'(1);
    end
    // Both at once leaves the count alone
    if (push && !pop) begin
      next_st.count = st.count + (AW+1)'(1);
    end else if (pop && !push) begin
      next_st.count = st.count - (AW+1)'(1);
    end
    // Ready is worked out from the next count so it never lags a push
    next_st.ready = (next_st.count != (AW+1)'(DEPTH));
  end

  // Register the state; storage needs no reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st.wr <= '0;
      st.rd <= '0;
      st.count <= '0;
      st.ready <= 1'b1;
      st.mem <= next_st.mem;
    end else begin
      st <= next_st;
    end
  end

  // Occupancy never exceeds the depth
  property p_fifo_bound;
    @(posedge clk) disable iff (!nrst) st.count <= (AW+1)'(DEPTH);
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count over depth");

  // Registered ready agrees with the occupancy
  property p_fifo_ready;
    @(posedge clk) disable iff (!nrst) st.ready == (st.count != (AW+1)'(DEPTH));
  endproperty
  a_fifo_ready: assert property (p_fifo_ready) else $error("fifo ready disagrees with count");
endmodule

// ---- core/pdl_latch.sv ----
// Parallel DAC input latch: capture, segment decode and output codes
`timescale 1ns/1ps
// Functional notes
// - Rising clock captures word, updates outputs
// - Word is 12, 14 or 16 bits
// - Word is unsigned straight binary
// - Primary output full scale at all ones
// - Complementary full scale at all zeros
// - Top four bits make fifteen segments
// - Lower bits are binary weighted
// - Primary is code, complementary max minus code
// - Difference is twice code minus max

// Pipeline: a word taken from the host at edge n sits in the FIFO after
// edge n and reaches every output after edge n+1.
// The FIFO drains on every edge, so it holds at most one word and
// data_ready stays high; it only absorbs a host that runs ahead.
// Narrow family members are left-justified, so the segment decode always
// sees the top four bits of the real word. Limitation: the padded low bits
// stay zero, so a narrow all-ones word leaves those bits set in out_compl.
// Reset parks the code at zero, the quietest state for the primary output.
module pdl_latch #(
  parameter int unsigned WORD_W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [WORD_W-1:0] input_data_bits,
  input wire logic data_valid,
  output logic data_ready,
  output logic [pdl_pkg::DATA_W-1:0] out_primary,
  output logic [pdl_pkg::DATA_W-1:0] out_compl,
  output logic [pdl_pkg::SEG_N-1:0] seg_en,
  output logic [pdl_pkg::BIN_W-1:0] bin_en,
  output logic signed [pdl_pkg::DIFF_W-1:0] out_diff,
  output logic running
);
  // Narrow words are left-justified so the top bits always drive segments
  localparam int unsigned PAD_W = pdl_pkg::DATA_W - WORD_W;

  // Whole block state in one struct; all outputs except data_ready (from the FIFO) come from here
  typedef struct packed {
    pdl_pkg::pdl_state_e state;
    logic [pdl_pkg::DATA_W-1:0] code;
    logic [pdl_pkg::DATA_W-1:0] prim;
    logic [pdl_pkg::DATA_W-1:0] compl;
    logic [pdl_pkg::SEG_N-1:0] seg;
    logic [pdl_pkg::BIN_W-1:0] bin;
    logic signed [pdl_pkg::DIFF_W-1:0] diff;
  } pdl_latch_s;

  pdl_latch_s st;
  pdl_latch_s next_st;
  logic [pdl_pkg::DATA_W-1:0] fifo_word; // FIFO head, justified
  logic fifo_valid; // A sample waits at the head
  logic [pdl_pkg::DATA_W-1:0] in_word; // Justified input word
  logic [pdl_pkg::SEG_N-1:0] therm; // Thermometer of the new code
  logic [pdl_pkg::DATA_W-1:0] new_code; // Code that this edge captures

  generate
    if (PAD_W == 0) begin : g_full
      assign in_word = input_data_bits;
    end else begin : g_pad
      assign in_word = {input_data_bits, {PAD_W{1'b0}}};
    end
  endgenerate

  // Samples pass through here; drained every edge, so data_ready never throttles the host
  pdl_fifo #(
    .WIDTH(pdl_pkg::DATA_W),
    .DEPTH(pdl_pkg::FIFO_DEPTH),
    .AW(pdl_pkg::FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_data(in_word),
    .in_valid(data_valid),
    .in_ready(data_ready),
    .out_data(fifo_word),
    .out_valid(fifo_valid),
    .out_ready(1'b1)
  );

  // keep old code when nothing arrives
  assign new_code = fifo_valid ? fifo_word : st.code;

  // one segment per step of the top nibble
  generate
    for (genvar i = 0; i < pdl_pkg::SEG_N; i++) begin : g_seg
      assign therm[i] = (new_code[pdl_pkg::DATA_W-1 -: pdl_pkg::SEG_BITS] > 4'(i));
    end
  endgenerate

  // Next state; outputs are recomputed only when a word is captured
  always_comb begin
    next_st = st;
    case (st.state)
      pdl_pkg::PDL_IDLE: begin
        // First sample starts the running state
        if (fifo_valid) begin
          next_st.state = pdl_pkg::PDL_RUN;
        end
      end
      pdl_pkg::PDL_RUN: begin
        next_st.state = pdl_pkg::PDL_RUN;
      end
      default: begin
        next_st.state = pdl_pkg::PDL_IDLE;
      end
    endcase
    if (fifo_valid) begin
      // code is used unsigned as is
      next_st.code = new_code;
      next_st.prim = new_code;
      next_st.compl = pdl_pkg::CODE_MAX - new_code;
      next_st.seg = therm;
      next_st.bin = new_code[pdl_pkg::BIN_W-1:0];
      next_st.diff = $signed({2'b00, new_code}) - $signed({2'b00, pdl_pkg::CODE_MAX - new_code});
    end
  end

  // Synchronous reset: zero code, so complement sits at full scale
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st.state <= pdl_pkg::PDL_IDLE;
      st.code <= pdl_pkg::RST_CODE;
      st.prim <= pdl_pkg::RST_CODE;
      st.compl <= pdl_pkg::CODE_MAX;
      st.seg <= '0;
      st.bin <= '0;
      st.diff <= pdl_pkg::RST_DIFF;
    end else begin
      st <= next_st;
    end
  end

  assign out_primary = st.prim;
  assign out_compl = st.compl;
  assign seg_en = st.seg;
  assign bin_en = st.bin;
  assign out_diff = st.diff;
  // One-hot code: the RUN bit is the flop itself, no decode behind the port
  assign running = st.state[1];

  // outputs always sum to the maximum code
  property p_sum;
    @(posedge clk) disable iff (!nrst)
      (out_primary + out_compl) == pdl_pkg::CODE_MAX;
  endproperty
  a_sum: assert property (p_sum) else $error("outputs do not sum to max");

  property p_capture;
    @(posedge clk) disable iff (!nrst)
      fifo_valid |=> (out_primary == $past(fifo_word));
  endproperty
  a_capture: assert property (p_capture) else $error("word not captured");

  property p_hold;
    @(posedge clk) disable iff (!nrst)
      !fifo_valid |=> $stable(out_primary) && $stable(seg_en);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved without sample");

  property p_seg;
    @(posedge clk) disable iff (!nrst)
      $countones(seg_en) == int'(out_primary[pdl_pkg::DATA_W-1 -: pdl_pkg::SEG_BITS]);
  endproperty
  a_seg: assert property (p_seg) else $error("segment count wrong");

  property p_therm;
    @(posedge clk) disable iff (!nrst)
      ((seg_en + 15'h0001) & seg_en) == 15'h0000;
  endproperty
  a_therm: assert property (p_therm) else $error("segments not thermometer");

  // binary bits follow low code bits
  property p_bin;
    @(posedge clk) disable iff (!nrst)
      bin_en == out_primary[pdl_pkg::BIN_W-1:0];
  endproperty
  a_bin: assert property (p_bin) else $error("binary bits mismatch");

  // difference is twice code minus max
  property p_diff;
    @(posedge clk) disable iff (!nrst)
      out_diff == $signed({2'b00, out_primary}) * 2 - $signed({2'b00, pdl_pkg::CODE_MAX});
  endproperty
  a_diff: assert property (p_diff) else $error("difference wrong");

  // all-ones head empties the complement next edge
  property p_full;
    @(posedge clk) disable iff (!nrst)
      (fifo_valid && fifo_word == pdl_pkg::CODE_MAX) |=> out_compl == '0;
  endproperty
  a_full: assert property (p_full) else $error("full scale not reached");

  property p_ready;
    @(posedge clk) disable iff (!nrst)
      data_ready;
  endproperty
  a_ready: assert property (p_ready) else $error("input throttled unexpectedly");

  property p_run_set;
    @(posedge clk) disable iff (!nrst)
      fifo_valid |=> running;
  endproperty
  a_run_set: assert property (p_run_set) else $error("running not set on capture");

  property p_run_hold;
    @(posedge clk) disable iff (!nrst)
      running |=> running;
  endproperty
  a_run_hold: assert property (p_run_hold) else $error("running dropped");

  property p_prim_full;
    @(posedge clk) disable iff (!nrst)
      (fifo_valid && fifo_word == pdl_pkg::CODE_MAX) |=> out_primary == pdl_pkg::CODE_MAX;
  endproperty
  a_prim_full: assert property (p_prim_full) else $error("primary not at full scale");

  property p_compl_full;
    @(posedge clk) disable iff (!nrst)
      (fifo_valid && fifo_word == '0) |=> out_compl == pdl_pkg::CODE_MAX;
  endproperty
  a_compl_full: assert property (p_compl_full) else $error("complement not full");

  property p_seg_full;
    @(posedge clk) disable iff (!nrst)
      out_primary[pdl_pkg::DATA_W-1 -: pdl_pkg::SEG_BITS] == 4'hF |-> seg_en == 15'h7FFF;
  endproperty
  a_seg_full: assert property (p_seg_full) else $error("segments not all on");

  property p_seg_none;
    @(posedge clk) disable iff (!nrst)
      out_primary[pdl_pkg::DATA_W-1 -: pdl_pkg::SEG_BITS] == 4'h0 |-> seg_en == 15'h0000;
  endproperty
  a_seg_none: assert property (p_seg_none) else $error("segments not all off");

  property p_seg_half;
    @(posedge clk) disable iff (!nrst)
      out_primary[pdl_pkg::DATA_W-1 -: pdl_pkg::SEG_BITS] == 4'h8 |-> seg_en == 15'h00FF;
  endproperty
  a_seg_half: assert property (p_seg_half) else $error("segments wrong at mid nibble");

  property p_compl_cap;
    @(posedge clk) disable iff (!nrst)
      fifo_valid |=> out_compl == pdl_pkg::CODE_MAX - $past(fifo_word);
  endproperty
  a_compl_cap: assert property (p_compl_cap) else $error("complement not max minus code");

  property p_hold_rest;
    @(posedge clk) disable iff (!nrst)
      !fifo_valid |=> $stable(out_compl) && $stable(bin_en) && $stable(out_diff);
  endproperty
  a_hold_rest: assert property (p_hold_rest) else $error("output moved without sample");

  property p_sign;
    @(posedge clk) disable iff (!nrst)
      out_diff[pdl_pkg::DIFF_W-1] == !out_primary[pdl_pkg::DATA_W-1];
  endproperty
  a_sign: assert property (p_sign) else $error("difference sign wrong");

  property p_mid;
    @(posedge clk) disable iff (!nrst)
      out_primary == pdl_pkg::CODE_MID |-> out_diff == 18'sh00001;
  endproperty
  a_mid: assert property (p_mid) else $error("difference wrong at mid-scale");

  property p_diff_top;
    @(posedge clk) disable iff (!nrst)
      out_primary == pdl_pkg::CODE_MAX |-> out_diff == 18'sh0FFFF;
  endproperty
  a_diff_top: assert property (p_diff_top) else $error("difference wrong at full scale");

  property p_diff_bottom;
    @(posedge clk) disable iff (!nrst)
      out_primary == '0 |-> out_diff == pdl_pkg::RST_DIFF;
  endproperty
  a_diff_bottom: assert property (p_diff_bottom) else $error("difference wrong at zero");
endmodule

// ---- dv/pdl_host.sv ----
// Host model that presents straight-binary sample words with a valid level
`timescale 1ns/1ps
module pdl_host (
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic [15:0] word,
  input wire logic data_ready,
  output logic [15:0] input_data_bits,
  output logic data_valid
);
  // Word held until taken; idle lines toggle so stale data never looks valid
  always_ff @(posedge clk) begin
    if (!nrst) begin
      data_valid <= 1'b0;
      input_data_bits <= 16'h0000;
    end else if (data_valid && data_ready) begin
      data_valid <= 1'b0;
      input_data_bits <= ~input_data_bits;
    end else if (go && !data_valid) begin
      data_valid <= 1'b1;
      input_data_bits <= word;
    end else if (!data_valid) begin
      input_data_bits <= ~input_data_bits;
    end
  end
endmodule

// ---- dv/pdl_latch_tb_top.sv ----
// Self-checking bench for the parallel DAC input latch
`timescale 1ns/1ps
module pdl_latch_tb_top;
  logic clk = 1'b0; // Bench clock, 8 ns period
  logic nrst = 1'b0; // Active-low synchronous reset
  logic go = 1'b0; // Request to the host model
  logic [15:0] word = 16'h0000; // Word handed to the host model
  logic [15:0] din; // Data lines from host
  logic dval; // Valid from host
  logic drdy; // Ready from design
  logic [15:0] prim, compl; // Primary and complementary codes
  logic [14:0] seg; // Segment enables
  logic [11:0] bin; // Binary enables
  logic signed [17:0] diff; // Differential code
  logic run; // Running flag
  int num_errors = 0;
  int total_checks = 0;
  // Corner codes: ends, mid-scale, segment edges, one mixed pattern
  logic [15:0] codes [8] = '{16'h0000, 16'hFFFF, 16'h8000, 16'h7FFF,
    16'h0FFF, 16'h1000, 16'hF000, 16'hA5C3};
  always #4 clk = ~clk;
  pdl_host host (.clk(clk), .nrst(nrst), .go(go), .word(word), .data_ready(drdy),
    .input_data_bits(din), .data_valid(dval));
  pdl_latch #(.WORD_W(16)) dut (.clk(clk), .nrst(nrst), .input_data_bits(din),
    .data_valid(dval), .data_ready(drdy), .out_primary(prim), .out_compl(compl),
    .seg_en(seg), .bin_en(bin), .out_diff(diff), .running(run));
  // One compare, counted
  task chk(input string name, input logic [17:0] exp, input logic [17:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Compare every output against the code the latch should hold
  task chk_all(input logic [15:0] w, input logic r);
    logic [15:0] th;
    th = (16'h0001 << w[15:12]) - 16'h0001;
    chk("primary", {2'b00, w}, {2'b00, prim});
    chk("compl", {2'b00, 16'hFFFF - w}, {2'b00, compl});
    chk("seg", {3'b000, th[14:0]}, {3'b000, seg});
    chk("bin", {6'h00, w[11:0]}, {6'h00, bin});
    chk("diff", {1'b0, w, 1'b0} - 18'h0FFFF, diff);
    chk("running", {17'h00000, r}, {17'h00000, run});
    chk("ready", 18'h00001, {17'h00000, drdy});
  endtask
  // Reset held two cycles, then reset values checked
  task reset_dut();
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    #1;
    chk_all(16'h0000, 1'b0);
    chk("ready", 18'h00001, {17'h00000, drdy});
  endtask
  // Send one word; outputs follow one edge after the edge that takes it
  task send(input logic [15:0] w);
    int n;
    word <= w;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    n = 0;
    while (!(dval && drdy) && n < 50) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 50) chk("taken", 18'h00001, 18'h00000);
    repeat (3) @(posedge clk);
    #1;
  endtask
  // Every corner code through the whole path
  task t_codes();
    foreach (codes[i]) begin
      send(codes[i]);
      chk_all(codes[i], 1'b1);
    end
  endtask
  // Data lines toggle while idle; captured word must not move
  task t_hold();
    send(16'h3C5A);
    repeat (8) begin
      @(posedge clk);
      #1;
      chk_all(16'h3C5A, 1'b1);
    end
  endtask
  // Verdict and end of run
  task finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence, with a second reset in mid-run
  initial begin
    reset_dut();
    t_codes();
    t_hold();
    reset_dut();
    t_codes();
    finish_test();
  end
  // Watchdog well beyond the roughly 80 cycles the tests need
  initial begin
    #20000;
    num_errors++;
    finish_test();
  end
endmodule
